// ### verilog/afc_consts.svh
// Offsets, field positions, reset values and timing counts of the flow controller
`ifndef AFC_CONSTS_SVH
`define AFC_CONSTS_SVH

`define FLOW_CONTROL_CONFIG_OFFSET      8'hac
`define FLOW_CONTROL_CONFIG_RESET       32'h0000_0000
`define FLOW_CONTROL_CONFIG_WMASK       32'h00ff_ffff
`define FILL_HIGH_THRESHOLD_MSB          23
`define FILL_HIGH_THRESHOLD_LSB          16
`define FILL_LOW_THRESHOLD_MSB          15
`define FILL_LOW_THRESHOLD_LSB          8
`define AFC_DUR_MSB         7
`define AFC_DUR_LSB         4
`define AFC_MULT_BIT        3
`define AFC_BRD_BIT         2
`define AFC_ADD_BIT         1
`define AFC_ANY_BIT         0
`define AFC_TRIG_MSB        3
`define AFC_TRIG_LSB        0
`define AFC_UNIT_SHIFT      6
`define AFC_FILL_MSB        13
`define AFC_PAUSE_ZERO      16'h0000
`define AFC_CLK_PERIOD_NS   10
`define AFC_US_NS           1000
`define AFC_CYC_PER_US      (`AFC_US_NS / `AFC_CLK_PERIOD_NS)
`define AFC_EXTRA_10M_NS    2200
`define AFC_EXTRA_10M_CYC   (`AFC_EXTRA_10M_NS / `AFC_CLK_PERIOD_NS)

`endif

// ### verilog/afc_pkg.sv
// Types shared by the flow controller files
package afc_pkg;

  typedef enum logic [0:0] {
    AFC_IDLE   = 1'b0,
    AFC_PAUSED = 1'b1
  } afc_state_t;

  typedef logic [19:0] afc_jam_count_t;

endpackage

// ### verilog/afc_jam_timer.sv
// Back-pressure duration timer with the duration code lookup
`timescale 1ns/100ps
`include "afc_consts.svh"

module afc_jam_timer #(
  parameter int CYC_PER_US = `AFC_CYC_PER_US
) (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       start,
  input  wire logic       abort,
  input  wire logic       speed100,
  input  wire logic [3:0] duration,
  output logic            active
);

  afc_pkg::afc_jam_count_t count;
  afc_pkg::afc_jam_count_t next_count;
  logic                    next_active;

  // Whole microseconds of the 100 Mb/s column
  function automatic logic [9:0] durUs(input logic [3:0] code);
    unique case (code)
      4'h0:    durUs = 10'h005;
      4'h1:    durUs = 10'h00a;
      4'h2:    durUs = 10'h00f;
      4'h3:    durUs = 10'h019;
      default: durUs = 10'(10'(code - 4'h3) * 10'h032);
    endcase
  endfunction

  function automatic afc_pkg::afc_jam_count_t durCycles(input logic [3:0] code, input logic fast);
    int total;
    total = int'(durUs(code)) * CYC_PER_US;
    if (!fast) begin
      total = total + `AFC_EXTRA_10M_CYC;
    end
    durCycles = 20'(total);
  endfunction

  always_comb begin
    next_count = count;
    if (abort) begin
      next_count = '0;
    end else if (start) begin
      next_count = durCycles(duration, speed100);
    end else if (count != '0) begin
      next_count = count - 20'h00001;
    end
    next_active = (next_count != '0);
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      count  <= '0;
      active <= 1'b0;
    end else begin
      count  <= next_count;
      active <= next_active;
    end
  end

endmodule // afc_jam_timer

// ### verilog/afc_flow_ctrl.sv
// Automatic receive flow control: pause frames in full duplex, timed jamming in half duplex
//
// Overview of operation
// [R1] No pause or jam while transmitter disabled
// [R2] High threshold bits 23:16 in 64-byte units
// [R3] Full duplex: one pause frame per high event
// [R4] Half duplex: jam each matching frame for duration
// [R5] Below low threshold: send zero-time pause
// [R6] Resume only after a real high pause
// [R7] Resume only with automatic flow control enabled
// [R8] Software keeps low threshold under high
// [R9] Duration field bits 7:4, half duplex only
// [R10] Bit 3 jams multicast frames past threshold
// [R11] Bit 2 jams broadcast frames past threshold
// [R12] Bit 1 jams own-address frames past threshold
// [R13] Bit 0 any-frame; enables full-duplex pausing
// [R14] Any-frame half duplex jams at next preamble
// [R15] Any-frame full duplex requests pause immediately
// [R16] Any-frame bit overrides bits 3:1
// [R17] Armed flag tracks whether resume is owed
`timescale 1ns/100ps
`include "afc_consts.svh"

module afc_flow_ctrl #(
  parameter int CYC_PER_US = `AFC_CYC_PER_US
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic [7:0]  regAddr,
  input  wire logic        regWrEn,
  input  wire logic [31:0] regWrData,
  input  wire logic        regRdEn,
  output logic      [31:0] regRdData,
  input  wire logic        txEnabled,
  input  wire logic        fullDuplex,
  input  wire logic        speed100,
  input  wire logic [13:0] rxFifoBytes,
  input  wire logic [15:0] pauseTimeValue,
  input  wire logic        rxPreamble,
  input  wire logic        rxAddrValid,
  input  wire logic        rxIsMulticast,
  input  wire logic        rxIsBroadcast,
  input  wire logic        rxIsOwnAddr,
  output logic             pauseReq,
  output logic      [15:0] pauseReqTime,
  output logic             backPressure
);

  logic [31:0]         flowControlConfig;
  logic [31:0]         next_flowControlConfig;
  logic [31:0]         next_regRdData;
  afc_pkg::afc_state_t state;
  afc_pkg::afc_state_t next_state;
  logic                next_pauseReq;
  logic [15:0]         next_pauseReqTime;

  logic [7:0] fillHighThreshold;
  logic [7:0] fillLowThreshold;
  logic [3:0] jamDuration;
  logic       multicastJamEnable;
  logic       broadcastJamEnable;
  logic       ownAddressJamEnable;
  logic       anyFrameTrigger;
  logic       autoEnabled;
  logic [7:0] fillUnits;
  logic       highReached;
  logic       belowLow;
  logic       fdHighPause;
  logic       fdResume;
  logic       frameMatch;
  logic       jamStart;
  logic       jamAbort;
  logic       jamActive;

  // Register file
  always_comb begin
    next_flowControlConfig = flowControlConfig;
    next_regRdData         = regRdData;
    if (regWrEn && regAddr == `FLOW_CONTROL_CONFIG_OFFSET) begin
      next_flowControlConfig = regWrData & `FLOW_CONTROL_CONFIG_WMASK;
    end
    if (regRdEn) begin
      next_regRdData = (regAddr == `FLOW_CONTROL_CONFIG_OFFSET) ? flowControlConfig : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      flowControlConfig <= `FLOW_CONTROL_CONFIG_RESET;
      regRdData         <= 32'h0000_0000;
    end else begin
      flowControlConfig <= next_flowControlConfig;
      regRdData         <= next_regRdData;
    end
  end

  assign fillHighThreshold   = flowControlConfig[`FILL_HIGH_THRESHOLD_MSB:`FILL_HIGH_THRESHOLD_LSB];
  assign fillLowThreshold    = flowControlConfig[`FILL_LOW_THRESHOLD_MSB:`FILL_LOW_THRESHOLD_LSB];
  assign jamDuration         = flowControlConfig[`AFC_DUR_MSB:`AFC_DUR_LSB];
  assign multicastJamEnable  = flowControlConfig[`AFC_MULT_BIT];
  assign broadcastJamEnable  = flowControlConfig[`AFC_BRD_BIT];
  assign ownAddressJamEnable = flowControlConfig[`AFC_ADD_BIT];
  assign anyFrameTrigger     = flowControlConfig[`AFC_ANY_BIT];
  assign autoEnabled         = (flowControlConfig[`AFC_TRIG_MSB:`AFC_TRIG_LSB] != 4'h0);

  // Partial 64-byte units do not count toward a level
  assign fillUnits   = rxFifoBytes[`AFC_FILL_MSB:`AFC_UNIT_SHIFT];
  assign highReached = (fillUnits >= fillHighThreshold); // R2
  assign belowLow    = (fillUnits < fillLowThreshold); // R5

  // Full duplex high pause needs the any-frame bit; the zero-time resume needs any of bits 3:0
  assign fdHighPause = (state == afc_pkg::AFC_IDLE) && fullDuplex && anyFrameTrigger
                       && txEnabled && highReached; // R1 R3 R13 R15
  assign fdResume    = (state == afc_pkg::AFC_PAUSED) && autoEnabled && txEnabled
                       && belowLow; // R1 R5 R6 R7

  always_comb begin
    next_state        = state;
    next_pauseReq     = 1'b0;
    next_pauseReqTime = pauseReqTime;
    unique case (state)
      afc_pkg::AFC_IDLE: begin
        if (fdHighPause) begin
          next_state        = afc_pkg::AFC_PAUSED; // R17
          next_pauseReq     = 1'b1; // R3
          next_pauseReqTime = pauseTimeValue; // R3
        end
      end
      afc_pkg::AFC_PAUSED: begin
        if (fdResume) begin
          next_state        = afc_pkg::AFC_IDLE; // R17
          next_pauseReq     = 1'b1; // R5
          next_pauseReqTime = `AFC_PAUSE_ZERO; // R5
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state        <= afc_pkg::AFC_IDLE;
      pauseReq     <= 1'b0;
      pauseReqTime <= 16'h0000;
    end else begin
      state        <= next_state;
      pauseReq     <= next_pauseReq;
      pauseReqTime <= next_pauseReqTime;
    end
  end

  // Any-frame skips address decode and overrides the per-type bits
  assign frameMatch = anyFrameTrigger ? rxPreamble // R14 R16
                    : rxAddrValid && ((multicastJamEnable && rxIsMulticast) // R10
                                   || (broadcastJamEnable && rxIsBroadcast) // R11
                                   || (ownAddressJamEnable && rxIsOwnAddr)); // R12
  // A frame arriving while jamming is already covered by the running period
  assign jamStart = !fullDuplex && txEnabled && highReached && !jamActive && frameMatch; // R4
  assign jamAbort = fullDuplex || !txEnabled; // R1 R9

  afc_jam_timer #(
    .CYC_PER_US (CYC_PER_US)
  ) u_jam_timer (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .start    (jamStart),
    .abort    (jamAbort),
    .speed100 (speed100),
    .duration (jamDuration), // R9
    .active   (jamActive)
  );

  assign backPressure = jamActive && txEnabled && !fullDuplex; // R1 R9

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_pause_tx_on: assert property (pauseReq |-> $past(txEnabled)) // R1
    else $error("pause requested with transmitter disabled");
  a_jam_tx_on: assert property (backPressure |-> txEnabled && !fullDuplex) // R1
    else $error("back pressure while disabled or full duplex");
  a_high_pause: assert property (fdHighPause |=> pauseReq && pauseReqTime == $past(pauseTimeValue)) // R3
    else $error("high level did not request pause with programmed time");
  a_one_pause: assert property ((state == afc_pkg::AFC_PAUSED) && !fdResume |=> !pauseReq) // R3
    else $error("extra pause while armed");
  a_resume_zero: assert property (fdResume |=> pauseReq && pauseReqTime == 16'h0000
                                  && state == afc_pkg::AFC_IDLE) // R5
    else $error("resume pause missing or nonzero");
  a_resume_owed: assert property ($fell(state) |-> pauseReq && pauseReqTime == 16'h0000) // R6
    else $error("armed flag dropped without resume frame");
  a_resume_enabled: assert property ((state == afc_pkg::AFC_PAUSED) && !autoEnabled
                                     |=> state == afc_pkg::AFC_PAUSED) // R7
    else $error("resume issued with flow control disabled");
  a_jam_starts: assert property (jamStart ##1 !jamAbort |-> backPressure) // R4
    else $error("matching frame not jammed");
  a_any_preamble: assert property (!fullDuplex && txEnabled && highReached && anyFrameTrigger
                                   && rxPreamble && !jamActive |=> jamActive) // R14
    else $error("preamble not jammed in any-frame mode");
  a_any_override: assert property (anyFrameTrigger && !rxPreamble && !jamActive |=> !jamActive) // R16
    else $error("type bits acted in any-frame mode");
  a_fd_no_jam: assert property (fullDuplex |-> !backPressure) // R9
    else $error("back pressure in full duplex");

  c_high_pause: cover property (fdHighPause ##1 pauseReq);
  c_resume: cover property (fdResume ##1 pauseReq);
  c_mcast_jam: cover property (!anyFrameTrigger && rxIsMulticast && jamStart ##1 backPressure);
  c_any_jam: cover property (anyFrameTrigger && jamStart ##1 backPressure);

endmodule // afc_flow_ctrl

// ### tb/afc_station_model.sv
// Remote station stand-in: sends frame headers and counts pause frames
`timescale 1ns/100ps
module afc_station_model (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        pauseReq,
  input  wire logic [15:0] pauseReqTime,
  output logic             rxPreamble,
  output logic             rxAddrValid,
  output logic      [2:0]  rxKind
);
  int          pauseCount;
  logic [15:0] lastTime;
  initial begin
    rxPreamble = 1'b0;
    rxAddrValid = 1'b0;
    rxKind = 3'h7;
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pauseCount <= 0;
      lastTime <= 16'h0000;
    end else if (pauseReq) begin
      pauseCount <= pauseCount + 1;
      lastTime <= pauseReqTime;
    end
  end
  // Kind is {multicast, broadcast, own}; inverted outside decode so stale values never help
  task automatic send_frame(input logic [2:0] kind);
    @(negedge clk_sys) rxPreamble = 1'b1;
    @(negedge clk_sys) rxPreamble = 1'b0;
    rxAddrValid = 1'b1;
    rxKind = kind;
    @(negedge clk_sys) rxAddrValid = 1'b0;
    rxKind = ~kind;
  endtask
endmodule // afc_station_model

// ### tb/afc_flow_ctrl_bench.sv
// Self-checking bench for the automatic flow controller
`timescale 1ns/100ps
module afc_flow_ctrl_bench;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  regAddr = 8'hac;
  logic        regWrEn = 1'b0;
  logic [31:0] regWrData = 32'h0;
  logic        regRdEn = 1'b0;
  logic [31:0] regRdData;
  logic        txEnabled = 1'b1;
  logic        fullDuplex = 1'b1;
  logic        speed100 = 1'b1;
  logic [13:0] rxFifoBytes = 14'h0;
  logic [15:0] pauseTimeValue = 16'h1234;
  logic        rxPreamble, rxAddrValid, pauseReq, backPressure;
  logic [2:0]  rxKind;
  logic [15:0] pauseReqTime;
  int          miscompares = 0;
  int          comparisons = 0;
  int          cycles = 0;
  int          jamCycles;
  always #5 clk_sys = ~clk_sys;
  afc_flow_ctrl #(.CYC_PER_US(1)) i_afc_flow_ctrl (.clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr),
    .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData), .txEnabled(txEnabled),
    .fullDuplex(fullDuplex), .speed100(speed100), .rxFifoBytes(rxFifoBytes), .pauseTimeValue(pauseTimeValue),
    .rxPreamble(rxPreamble), .rxAddrValid(rxAddrValid), .rxIsMulticast(rxKind[2]), .rxIsBroadcast(rxKind[1]),
    .rxIsOwnAddr(rxKind[0]), .pauseReq(pauseReq), .pauseReqTime(pauseReqTime), .backPressure(backPressure));
  afc_station_model i_afc_station_model (.clk_sys(clk_sys), .rst_n(rst_n), .pauseReq(pauseReq),
    .pauseReqTime(pauseReqTime), .rxPreamble(rxPreamble), .rxAddrValid(rxAddrValid), .rxKind(rxKind));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("Comparisons %0d, miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk_sys) regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(negedge clk_sys) regWrEn = 1'b0;
  endtask
  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(negedge clk_sys) regAddr = a;
    regRdEn = 1'b1;
    @(negedge clk_sys) regRdEn = 1'b0;
    d = regRdData;
  endtask
  // Samples the current cycle first, so a jam begun at the preamble shows one cycle less
  task automatic count_jam(input int window);
    jamCycles = 0;
    repeat (window) begin
      if (backPressure === 1'b1) jamCycles++;
      @(negedge clk_sys);
    end
  endtask
  task automatic t_regs;
    logic [31:0] d;
    reg_read(8'hac, d);
    check(d, 32'h0);
    reg_write(8'hac, 32'hffff_ffff);
    reg_read(8'hac, d);
    check(d, 32'h00ff_ffff);
    reg_read(8'ha8, d);
    check(d, 32'h0);
    $display("Register test done");
  endtask
  task automatic t_pause;
    reg_write(8'hac, 32'h0004_0201);
    txEnabled = 1'b0;
    rxFifoBytes = 14'd256;
    repeat (5) @(negedge clk_sys);
    check(i_afc_station_model.pauseCount, 0);
    txEnabled = 1'b1;
    @(negedge clk_sys);
    check(pauseReq, 1'b1);
    check(pauseReqTime, 16'h1234);
    rxFifoBytes = 14'd191;
    repeat (8) @(negedge clk_sys);
    check(i_afc_station_model.pauseCount, 1);
    rxFifoBytes = 14'd127;
    @(negedge clk_sys);
    check(pauseReq, 1'b1);
    check(pauseReqTime, 16'h0);
    repeat (5) @(negedge clk_sys);
    check(i_afc_station_model.pauseCount, 2);
    pauseTimeValue = 16'h5a3c;
    rxFifoBytes = 14'd256;
    repeat (3) @(negedge clk_sys);
    check(i_afc_station_model.lastTime, 16'h5a3c);
    reg_write(8'hac, 32'h0004_0200);
    rxFifoBytes = 14'd0;
    repeat (5) @(negedge clk_sys);
    check(i_afc_station_model.pauseCount, 3);
    reg_write(8'hac, 32'h0004_0202);
    repeat (3) @(negedge clk_sys);
    check(i_afc_station_model.pauseCount, 4);
    check(i_afc_station_model.lastTime, 16'h0);
    rxFifoBytes = 14'd256;
    repeat (5) @(negedge clk_sys);
    check(i_afc_station_model.pauseCount, 4);
    $display("Pause test done");
  endtask
  task automatic t_jam;
    fullDuplex = 1'b0;
    for (int i = 0; i < 3; i++) begin
      reg_write(8'hac, 32'h0004_0200 | (32'h8 >> i));
      i_afc_station_model.send_frame(3'h4 >> i);
      count_jam(20);
      check(jamCycles, 5);
    end
    reg_write(8'hac, 32'h0004_0208);
    i_afc_station_model.send_frame(3'h2);
    count_jam(20);
    check(jamCycles, 0);
    reg_write(8'hac, 32'h0004_021f);
    i_afc_station_model.send_frame(3'h7);
    count_jam(20);
    check(jamCycles, 9);
    reg_write(8'hac, 32'h0004_0208);
    txEnabled = 1'b0;
    i_afc_station_model.send_frame(3'h4);
    count_jam(20);
    check(jamCycles, 0);
    txEnabled = 1'b1;
    speed100 = 1'b0;
    i_afc_station_model.send_frame(3'h4);
    count_jam(300);
    check(jamCycles, 225);
    fullDuplex = 1'b1;
    i_afc_station_model.send_frame(3'h4);
    count_jam(20);
    check(jamCycles, 0);
    $display("Jam test done");
  endtask
  // Whole run needs about 530 cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (3) @(negedge clk_sys);
    rst_n = 1'b1;
    t_regs();
    t_pause();
    t_jam();
    tally_and_finish();
  end
endmodule // afc_flow_ctrl_bench
